// ---- sfu_pkg.sv ----
// Purpose: shared constants and state types for the flash unlock/OTP link
// Assumes: serial link in SPI mode 0, bytes shifted most significant first
// Notes:   the device end and the host end both import this package
package sfu_pkg;
   // command opcodes
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_OTP_PROGRAM   = 8'h9B;
   // frame layout in link clocks
   localparam int OPCODE_BITS   = 8;
   localparam int ADDR_BYTES    = 3;
   localparam int OTP_HDR_BITS  = 32;
   localparam int FRAME_CNT_W   = 14;
   // OTP layout: register select in 8:7, byte offset in 6:0
   localparam int OTP_ADDR_W    = 9;
   localparam int OTP_OFFS_W    = 7;
   localparam int OTP_SEL_W     = 2;
   localparam int OTP_BYTES     = 512;
   localparam int OTP_REG_BYTES = 128;
   localparam logic [6:0] OTP_MSB_OFFS = 7'h7F;
   localparam logic [7:0] OTP_ERASED   = 8'hFF;
   // staging buffer
   localparam int BUF_BYTES     = 256;
   localparam int BUF_IDX_W     = 8;
   localparam int DATA_CNT_W    = 9;
   // reset values and timing counts in core clocks
   localparam logic BLOCK_LOCK_RESET = 1'b1;
   localparam int OTP_BYTE_CYCLES = 4;
   localparam int SCK_HALF_CYCLES = 2;
   localparam int CS_GAP_CYCLES   = 4;
   // state types
   typedef enum logic {DEV_IDLE, DEV_PROG} sfu_dev_state_t;
   typedef enum logic [2:0] {
      HST_IDLE, HST_SHIFT, HST_FETCH, HST_END, HST_GAP
   } sfu_host_state_t;
endpackage

// ---- sfu_spi_if.sv ----
// Purpose: serial link between the flash device end and the host end
// Assumes: host drives all three wires; device only listens here
// Notes:   cs_n is active low, sck idles low between frames
interface sfu_spi_if;
   logic cs_n;   // chip select, active low
   logic sck;    // serial clock from host
   logic si;     // serial data into the device
   modport device (input cs_n, input sck, input si);
   modport host   (output cs_n, output sck, output si);
endinterface

// ---- sfu_flash_dev.sv ----
// Purpose: flash command handling for global unlock and OTP programming
// Assumes: frame shifted on sck rising edges; core_clk_i finishes the work
// Notes:   frame results cross on the synchronised rise of cs_n
module sfu_flash_dev #(
   parameter int         NUM_BLOCKS       = 256,
   parameter int         BYTE_PROG_CYCLES = sfu_pkg::OTP_BYTE_CYCLES,
   parameter logic [7:0] FACTORY_SEED     = 8'h5A  // arbitrary pattern
) (
   input  wire logic                          core_clk_i,      // core clock
   input  wire logic                          rst_i,           // sync reset
   sfu_spi_if.device                          spi,             // link pins
   input  wire logic [sfu_pkg::OTP_ADDR_W-1:0] otp_rd_addr_i,  // peek addr
   output logic [7:0]                         otp_rd_data_o,   // peek data
   output logic [NUM_BLOCKS-1:0]              block_lock_o,    // lock bits
   output logic [2:0]                         otp_lock_flags_o, // regs 3:1
   output logic                               write_enable_latch_o, // latch
   output logic                               busy_o,          // programming
   output logic                               done_o,          // op pulse
   output logic                               abort_o          // abort pulse
);
   import sfu_pkg::*;

   // ---------------- link domain (spi.sck) ----------------
   logic [FRAME_CNT_W-1:0] bit_cnt_reg;
   logic                   fresh_reg;
   logic [7:0]             shift_reg;
   logic [7:0]             opcode_reg;
   logic [23:0]            addr_reg;
   logic [7:0]             stage_buf [BUF_BYTES];

   // serial decode of the running frame; a fresh frame counts from zero
   wire [FRAME_CNT_W-1:0] bit_cur    = fresh_reg ? '0 : bit_cnt_reg;
   wire [6:0]             shift_old  = fresh_reg ? 7'h00 : shift_reg[6:0];
   wire [7:0]             shift_next = {shift_old, spi.si};
   wire                   byte_end   = bit_cur[2:0] == 3'h7;
   wire                   in_addr    = bit_cur >= FRAME_CNT_W'(OPCODE_BITS)
                                    && bit_cur < FRAME_CNT_W'(OTP_HDR_BITS);
   wire                   in_data    = bit_cur >= FRAME_CNT_W'(OTP_HDR_BITS);
   wire [FRAME_CNT_W-1:0] data_bit   = bit_cur - FRAME_CNT_W'(OTP_HDR_BITS);
   wire [BUF_IDX_W-1:0]   buf_wr_idx = data_bit[BUF_IDX_W+2:3];

   // fresh-frame marker: set while cs_n is high, dropped by the first clock
   always_ff @(posedge spi.sck or posedge spi.cs_n) begin
      if (spi.cs_n)
         fresh_reg <= 1'b1;
      else
         fresh_reg <= 1'b0;
   end

   // bit counter, opcode and address; kept after cs_n rises for the judge
   always_ff @(posedge spi.sck) begin
      if (bit_cur != '1)
         bit_cnt_reg <= bit_cur + 1'b1;
      shift_reg <= shift_next;
      if (bit_cur == FRAME_CNT_W'(OPCODE_BITS - 1))
         opcode_reg <= shift_next;
      if (in_addr)
         addr_reg <= {addr_reg[22:0], spi.si};
   end

   // staging buffer, one byte per eight clocks, index wraps at 256
   always_ff @(posedge spi.sck) begin
      if (opcode_reg == OP_OTP_PROGRAM && in_data && byte_end)
         stage_buf[buf_wr_idx] <= shift_next;
   end

   // ---------------- core domain ----------------
   logic                  cs_meta_reg, cs_sync_reg, cs_last_reg;
   sfu_dev_state_t        state_reg;
   logic                  wen_reg, busy_reg, done_reg, abort_reg;
   logic [NUM_BLOCKS-1:0] lock_reg;
   logic [OTP_ADDR_W-1:0] prog_addr_reg;
   logic [BUF_IDX_W-1:0]  prog_idx_reg;
   logic [DATA_CNT_W-1:0] prog_left_reg;
   logic [7:0]            wait_reg;
   logic [7:0]            otp_mem [OTP_BYTES];
   logic [7:0]            rd_data_reg;
   logic [2:0]            flags_reg;

   // register lock: 0 is factory locked, 1-3 lock once their MSB is used
   function automatic logic reg_locked(input logic [OTP_SEL_W-1:0] sel);
      reg_locked = (sel == '0) ||
                   (otp_mem[{sel, OTP_MSB_OFFS}] != OTP_ERASED);
   endfunction

   // frame verdict, read only after cs_n has settled high in this domain
   wire frame_end = cs_sync_reg & ~cs_last_reg;
   wire accept    = frame_end && state_reg == DEV_IDLE;
   wire [FRAME_CNT_W-1:0] bits = bit_cnt_reg;
   wire has_op    = bits >= FRAME_CNT_W'(OPCODE_BITS);
   wire whole     = bits[2:0] == 3'h0;
   wire has_hdr   = bits >= FRAME_CNT_W'(OTP_HDR_BITS);
   wire is_wren   = has_op && opcode_reg == OP_WRITE_ENABLE && whole;
   wire is_unlock = has_op && opcode_reg == OP_GLOBAL_UNLOCK && wen_reg;
   wire is_prog   = has_op && opcode_reg == OP_OTP_PROGRAM && wen_reg;
   wire [OTP_ADDR_W-1:0] start_addr = addr_reg[OTP_ADDR_W-1:0];
   wire [FRAME_CNT_W-1:0] data_bits  = bits - FRAME_CNT_W'(OTP_HDR_BITS);
   wire [FRAME_CNT_W-1:0] nbytes_raw = data_bits >> 3;
   wire [DATA_CNT_W-1:0]  nbytes = (nbytes_raw > FRAME_CNT_W'(BUF_BYTES)) ?
                                   DATA_CNT_W'(BUF_BYTES) :
                                   nbytes_raw[DATA_CNT_W-1:0];
   wire prog_bad  = !has_hdr || !whole;
   wire prog_lock = reg_locked(start_addr[OTP_ADDR_W-1:OTP_OFFS_W]);
   wire prog_go   = is_prog && !prog_bad && !prog_lock && nbytes != '0;
   wire step      = state_reg == DEV_PROG && wait_reg == 8'h00;
   wire last_step = step && prog_left_reg == DATA_CNT_W'(1);

   // two-flop synchroniser plus edge history for chip select
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_last_reg <= 1'b1;
      end else begin
         cs_meta_reg <= spi.cs_n;
         cs_sync_reg <= cs_meta_reg;
         cs_last_reg <= cs_sync_reg;
      end
   end

   // write enable latch and block lock bits
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wen_reg  <= 1'b0;
         lock_reg <= {NUM_BLOCKS{BLOCK_LOCK_RESET}};
      end else if (accept) begin
         if (is_wren)
            wen_reg <= 1'b1;
         else if (is_unlock && whole) begin
            lock_reg <= '0;
            wen_reg  <= 1'b0;
         end else if (is_prog)
            wen_reg <= 1'b0;                // any program, ragged too
      end
   end

   // program sequencer, self-timed per byte
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg     <= DEV_IDLE;
         busy_reg      <= 1'b0;
         done_reg      <= 1'b0;
         abort_reg     <= 1'b0;
         prog_addr_reg <= '0;
         prog_idx_reg  <= '0;
         prog_left_reg <= '0;
         wait_reg      <= '0;
      end else begin
         done_reg  <= 1'b0;
         abort_reg <= 1'b0;
         case (state_reg)
            DEV_IDLE: begin
               if (accept && is_unlock) begin
                  done_reg  <= whole;
                  abort_reg <= !whole;
               end else if (accept && is_prog) begin
                  if (prog_go) begin
                     state_reg     <= DEV_PROG;
                     busy_reg      <= 1'b1;
                     prog_addr_reg <= start_addr;
                     prog_idx_reg  <= '0;
                     prog_left_reg <= nbytes;
                     wait_reg      <= 8'(BYTE_PROG_CYCLES - 1);
                  end else begin
                     done_reg  <= !prog_bad && !prog_lock;
                     abort_reg <= prog_bad || prog_lock;
                  end
               end
            end
            DEV_PROG: begin
               if (step) begin
                  prog_addr_reg <= prog_addr_reg + 1'b1;
                  prog_idx_reg  <= prog_idx_reg + 1'b1;
                  prog_left_reg <= prog_left_reg - 1'b1;
                  wait_reg      <= 8'(BYTE_PROG_CYCLES - 1);
               end else
                  wait_reg <= wait_reg - 1'b1;
               if (last_step) begin
                  state_reg <= DEV_IDLE;
                  busy_reg  <= 1'b0;
                  done_reg  <= 1'b1;
               end
            end
            default: state_reg <= DEV_IDLE;
         endcase
      end
   end

   // OTP array: reset models power-up content, programming only clears bits
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < OTP_BYTES; i++)
            otp_mem[i] <= (i < OTP_REG_BYTES) ? (FACTORY_SEED ^ 8'(i))
                                              : OTP_ERASED;
      end else if (step &&
                   !reg_locked(prog_addr_reg[OTP_ADDR_W-1:OTP_OFFS_W])) begin
         otp_mem[prog_addr_reg] <= otp_mem[prog_addr_reg]
                                 & stage_buf[prog_idx_reg];
      end
   end

   // registered status and peek port
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_data_reg <= '0;
         flags_reg   <= '0;
      end else begin
         rd_data_reg <= otp_mem[otp_rd_addr_i];
         flags_reg   <= {reg_locked(2'h3), reg_locked(2'h2), reg_locked(2'h1)};
      end
   end

   assign otp_rd_data_o    = rd_data_reg;
   assign otp_lock_flags_o = flags_reg;
   assign block_lock_o     = lock_reg;
   assign write_enable_latch_o = wen_reg;
   assign busy_o           = busy_reg;
   assign done_o           = done_reg;
   assign abort_o          = abort_reg;
endmodule

// ---- sfu_spi_host.sv ----
// Purpose: SPI master that frames write enable, unlock and OTP commands
// Assumes: mode 0; si changes after the falling sck edge
// Notes:   sck is core_clk_i divided; a tail of ragged bits can be added
module sfu_spi_host #(
   parameter int SCK_HALF = sfu_pkg::SCK_HALF_CYCLES,
   parameter int CS_GAP   = sfu_pkg::CS_GAP_CYCLES
) (
   input  wire logic        core_clk_i,      // core clock
   input  wire logic        rst_i,           // sync reset
   sfu_spi_if.host          spi,             // link pins
   input  wire logic        cmd_valid_i,     // command request
   input  wire logic [7:0]  cmd_opcode_i,    // opcode byte
   input  wire logic        cmd_send_addr_i, // append three address bytes
   input  wire logic [23:0] cmd_addr_i,      // address, msb first
   input  wire logic [9:0]  cmd_len_i,       // data bytes to send
   input  wire logic [2:0]  cmd_tail_bits_i, // extra ragged bits
   output logic             cmd_ready_o,     // idle, request taken
   input  wire logic [7:0]  wr_data_i,       // next data byte
   input  wire logic        wr_valid_i,      // data byte valid
   output logic             wr_ready_o,      // waiting for a data byte
   output logic             done_o           // frame finished pulse
);
   import sfu_pkg::*;

   sfu_host_state_t state_reg;
   logic [7:0]  div_reg, gap_reg, sr_reg;
   logic [2:0]  bit_left_reg, tail_reg;
   logic [1:0]  addr_left_reg;
   logic [9:0]  data_left_reg;
   logic [23:0] addr_reg;
   logic        sck_reg, cs_n_reg, ready_reg, wr_ready_reg, done_reg;

   // half-period tick of the divided link clock
   wire tick      = div_reg == 8'h00;
   wire take_cmd  = cmd_valid_i && ready_reg;
   wire take_data = wr_valid_i && wr_ready_reg;
   wire unit_done = tick && sck_reg && bit_left_reg == 3'h0;

   // framing state machine
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg     <= HST_IDLE;
         div_reg       <= '0;
         gap_reg       <= '0;
         sr_reg        <= '0;
         bit_left_reg  <= '0;
         tail_reg      <= '0;
         addr_left_reg <= '0;
         data_left_reg <= '0;
         addr_reg      <= '0;
         sck_reg       <= 1'b0;
         cs_n_reg      <= 1'b1;
         ready_reg     <= 1'b1;
         wr_ready_reg  <= 1'b0;
         done_reg      <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         div_reg  <= tick ? 8'(SCK_HALF - 1) : div_reg - 1'b1;
         case (state_reg)
            HST_IDLE: begin
               if (take_cmd) begin
                  state_reg     <= HST_SHIFT;
                  cs_n_reg      <= 1'b0;
                  ready_reg     <= 1'b0;
                  sr_reg        <= cmd_opcode_i;
                  bit_left_reg  <= 3'h7;
                  addr_left_reg <= cmd_send_addr_i ? 2'(ADDR_BYTES) : 2'h0;
                  addr_reg      <= cmd_addr_i;
                  data_left_reg <= cmd_len_i;
                  tail_reg      <= cmd_tail_bits_i;
                  div_reg       <= 8'(SCK_HALF - 1);
               end
            end
            HST_SHIFT: begin
               if (tick && !sck_reg)
                  sck_reg <= 1'b1;
               else if (tick) begin
                  sck_reg <= 1'b0;
                  if (!unit_done) begin
                     sr_reg       <= {sr_reg[6:0], 1'b0};
                     bit_left_reg <= bit_left_reg - 1'b1;
                  end else if (addr_left_reg != '0) begin
                     sr_reg        <= addr_reg[23:16];
                     addr_reg      <= {addr_reg[15:0], 8'h00};
                     addr_left_reg <= addr_left_reg - 1'b1;
                     bit_left_reg  <= 3'h7;
                  end else if (data_left_reg != '0) begin
                     state_reg    <= HST_FETCH;
                     wr_ready_reg <= 1'b1;
                  end else if (tail_reg != '0) begin
                     sr_reg       <= 8'h00;
                     bit_left_reg <= tail_reg - 1'b1;
                     tail_reg     <= '0;
                  end else
                     state_reg <= HST_END;
               end
            end
            HST_FETCH: begin
               if (take_data) begin
                  state_reg     <= HST_SHIFT;
                  wr_ready_reg  <= 1'b0;
                  sr_reg        <= wr_data_i;
                  bit_left_reg  <= 3'h7;
                  data_left_reg <= data_left_reg - 1'b1;
                  div_reg       <= 8'(SCK_HALF - 1);
               end
            end
            HST_END: begin
               if (tick) begin
                  cs_n_reg  <= 1'b1;
                  state_reg <= HST_GAP;
                  gap_reg   <= 8'(CS_GAP - 1);
               end
            end
            HST_GAP: begin
               gap_reg <= gap_reg - 1'b1;
               if (gap_reg == 8'h00) begin
                  state_reg <= HST_IDLE;
                  ready_reg <= 1'b1;
                  done_reg  <= 1'b1;
               end
            end
            default: state_reg <= HST_IDLE;
         endcase
      end
   end

   assign spi.cs_n    = cs_n_reg;
   assign spi.sck     = sck_reg;
   assign spi.si      = sr_reg[7];
   assign cmd_ready_o = ready_reg;
   assign wr_ready_o  = wr_ready_reg;
   assign done_o      = done_reg;
endmodule

// ---- sfu_asserts.sv ----
// Purpose: protocol checks on the unlock/OTP link and device status
// Assumes: single core clock domain, rst_i synchronous active high
// Notes:   instantiated beside the link interface in the bench
module sfu_asserts #(
   parameter int NUM_BLOCKS = 256
) (
   input wire logic                  core_clk_i,   // core clock
   input wire logic                  rst_i,        // sync reset
   input wire logic                  cs_n,         // link chip select
   input wire logic                  sck,          // link clock
   input wire logic                  si,           // link data in
   input wire logic [NUM_BLOCKS-1:0] block_lock_o, // block locks
   input wire logic                  write_enable_latch_o, // latch
   input wire logic                  busy_o,       // programming
   input wire logic                  done_o,       // op done pulse
   input wire logic                  abort_o       // abort pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // frame end and the high time that must follow it
   sequence s_cs_rise;
      $rose(cs_n);
   endsequence
   sequence s_cs_held;
      cs_n [*4];
   endsequence

   property p_cs_gap;
      s_cs_rise |-> s_cs_held;
   endproperty
   a_cs_gap: assert property (p_cs_gap)
      else $error("chip select high time too short");
   property p_sck_idle;
      cs_n |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("link clock moves outside a frame");
   property p_si_stable;
      sck |-> $stable(si);
   endproperty
   a_si_stable: assert property (p_si_stable)
      else $error("serial data moved while link clock high");
   property p_done_after_frame;
      done_o && !$past(busy_o) |-> $past(cs_n, 3) && $past(cs_n, 2);
   endproperty
   a_done_after_frame: assert property (p_done_after_frame)
      else $error("done came without a closed frame");
   property p_done_clears_latch;
      done_o |-> !write_enable_latch_o;
   endproperty
   a_done_clears_latch: assert property (p_done_clears_latch)
      else $error("write enable still set at done");
   property p_lock_change;
      $changed(block_lock_o) |-> done_o && (block_lock_o == '0);
   endproperty
   a_lock_change: assert property (p_lock_change)
      else $error("block locks changed other than by unlock");
   property p_abort_keeps;
      abort_o |-> $stable(block_lock_o);
   endproperty
   a_abort_keeps: assert property (p_abort_keeps)
      else $error("abort changed block locks");
   property p_pulse_excl;
      !(done_o && abort_o);
   endproperty
   a_pulse_excl: assert property (p_pulse_excl)
      else $error("done and abort together");
   property p_busy_done;
      $fell(busy_o) |-> done_o;
   endproperty
   a_busy_done: assert property (p_busy_done)
      else $error("programming ended without done");
   property p_busy_bound;
      $rose(busy_o) |-> ##[1:600] !busy_o;
   endproperty
   a_busy_bound: assert property (p_busy_bound)
      else $error("programming did not finish in time");
endmodule

// ---- sfu_bench.sv ----
// Purpose: host end drives device end over the link, results checked
// Assumes: inputs driven at falling edge, expected pulses kept in a queue
// Notes:   short byte program time keeps busy windows small
module sfu_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sfu_pkg::*;
   localparam logic [7:0] SEED_PAT = 8'hC3; // arbitrary factory pattern
   logic         core_clk_i;
   logic         rst_i;
   logic         cmd_valid;
   logic [7:0]   cmd_opcode;
   logic         cmd_send_addr;
   logic [23:0]  cmd_addr;
   logic [9:0]   cmd_len;
   logic [2:0]   cmd_tail;
   logic         cmd_ready;
   logic [7:0]   wr_data;
   logic         wr_valid;
   logic         wr_ready;
   logic         host_done;
   logic [8:0]   peek_addr;
   logic [7:0]   peek_data;
   logic [255:0] block_lock;
   logic [2:0]   otp_flags;
   logic         wr_en_latch;
   logic         busy;
   logic         dev_done;
   logic         dev_abort;
   logic [7:0]   dq [0:7];
   logic [3:0]   note_q [$];
   logic [6:0]   offs;
   logic [23:0]  addr;
   int           error_cnt;
   int           check_count;
   int           seed;
   int           n;

   sfu_spi_if sfu_spi_if_i ();
   sfu_flash_dev #(.BYTE_PROG_CYCLES(2), .FACTORY_SEED(SEED_PAT))
   sfu_flash_dev_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .spi(sfu_spi_if_i),
      .otp_rd_addr_i(peek_addr), .otp_rd_data_o(peek_data),
      .block_lock_o(block_lock), .otp_lock_flags_o(otp_flags),
      .write_enable_latch_o(wr_en_latch), .busy_o(busy),
      .done_o(dev_done), .abort_o(dev_abort));
   sfu_spi_host sfu_spi_host_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .spi(sfu_spi_if_i),
      .cmd_valid_i(cmd_valid), .cmd_opcode_i(cmd_opcode),
      .cmd_send_addr_i(cmd_send_addr), .cmd_addr_i(cmd_addr),
      .cmd_len_i(cmd_len), .cmd_tail_bits_i(cmd_tail),
      .cmd_ready_o(cmd_ready), .wr_data_i(wr_data), .wr_valid_i(wr_valid),
      .wr_ready_o(wr_ready), .done_o(host_done));
   sfu_asserts #(.NUM_BLOCKS(256)) sfu_asserts_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n(sfu_spi_if_i.cs_n),
      .sck(sfu_spi_if_i.sck), .si(sfu_spi_if_i.si),
      .block_lock_o(block_lock), .write_enable_latch_o(wr_en_latch),
      .busy_o(busy),
      .done_o(dev_done), .abort_o(dev_abort));

   // core clock, 50 ns period
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   // compare one seen value with its expectation
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // one host command with data bytes from dq, then settle the device
   task automatic run(input logic [7:0] op, input logic [23:0] a,
                      input int cnt, input logic [2:0] tail);
      int k;
      int i;
      k = 0;
      i = 0;
      cmd_opcode = op;
      cmd_send_addr = (op == OP_OTP_PROGRAM);
      cmd_addr = a;
      cmd_len = cnt[9:0];
      cmd_tail = tail;
      check({7'h0, cmd_ready}, 8'h01);
      cmd_valid = 1'b1;
      @(negedge core_clk_i);
      cmd_valid = 1'b0;
      while (host_done !== 1'b1 && k < 5000) begin
         @(negedge core_clk_i);
         k++;
         if (wr_valid) wr_valid = 1'b0;
         else if (wr_ready === 1'b1 && i < cnt) begin
            wr_data = dq[i];
            wr_valid = 1'b1;
            i++;
         end
      end
      repeat (6) @(negedge core_clk_i);
      while (busy !== 1'b0 && k < 5000) begin
         @(negedge core_clk_i);
         k++;
      end
      if (k >= 5000) begin
         error_cnt++;
         $display("[FAIL] %0t wait ran out", $time);
         end_of_test();
      end
   endtask

   // write enable, note the expected pulse, then program
   task automatic prog(input logic [23:0] a, input int cnt,
                       input logic [2:0] tail, input logic [3:0] note);
      run(OP_WRITE_ENABLE, 24'h0, 0, 3'h0);
      note_q.push_back(note);
      run(OP_OTP_PROGRAM, a, cnt, tail);
   endtask

   // read one array byte through the peek port
   task automatic peek(input logic [8:0] a, input logic [7:0] exp);
      peek_addr = a;
      @(negedge core_clk_i);
      check(peek_data, exp);
   endtask

   // every done or abort pulse matched against the oldest note
   always @(negedge core_clk_i) begin
      if (rst_i === 1'b0 && (dev_done === 1'b1 || dev_abort === 1'b1)) begin
         if (note_q.size() == 0) check(8'hEE, 8'h00);
         else check({4'h0, dev_done, dev_abort, wr_en_latch, |block_lock},
                    {4'h0, note_q.pop_front()});
      end
   end

   // main sequence
   initial begin
      seed = 12623;
      error_cnt = 0;
      check_count = 0;
      rst_i = 1'b1;
      cmd_valid = 1'b0;
      cmd_opcode = 8'h00;
      cmd_send_addr = 1'b0;
      cmd_addr = 24'h0;
      cmd_len = 10'h0;
      cmd_tail = 3'h0;
      wr_data = 8'h00;
      wr_valid = 1'b0;
      peek_addr = 9'h000;
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      // unlock without the latch is ignored
      run(OP_GLOBAL_UNLOCK, 24'h0, 0, 3'h0);
      check({6'h0, wr_en_latch, &block_lock}, 8'h01);
      run(OP_WRITE_ENABLE, 24'h0, 0, 3'h0);
      // ragged unlock aborts, then a clean one clears all locks
      note_q.push_back(4'b0111);
      run(OP_GLOBAL_UNLOCK, 24'h0, 0, 3'h3);
      note_q.push_back(4'b1000);
      run(OP_GLOBAL_UNLOCK, 24'h0, 0, 3'h0);
      // random bytes into register 1, upper address bits random
      for (int i = 0; i < 8; i++) dq[i] = 8'($random(seed));
      offs = 7'({$random(seed)} % 100);
      n = 1 + {$random(seed)} % 8;
      addr = {15'($random(seed)), 2'b01, offs};
      prog(addr, n, 3'h0, 4'b1000);
      for (int i = 0; i <= n; i++)
         peek(9'h080 + 9'(offs) + 9'(i), (i < n) ? dq[i] : OTP_ERASED);
      // factory register is refused
      prog({15'($random(seed)), 9'h005}, 1, 3'h0, 4'b0100);
      peek(9'h005, SEED_PAT ^ 8'h05);
      // ragged data byte aborts and clears the latch
      prog(24'h000180, 1, 3'h4, 4'b0100);
      peek(9'h180, OTP_ERASED);
      // top byte of register 2 locks it against later programs
      dq[0] = 8'h00;
      prog(24'h00017F, 1, 3'h0, 4'b1000);
      check({5'h0, otp_flags}, 8'h02);
      dq[0] = 8'h0F;
      prog(24'h000100, 1, 3'h0, 4'b0100);
      peek(9'h100, OTP_ERASED);
      check(8'(note_q.size()), 8'h00);
      end_of_test();
   end
endmodule
